// >>> core/dcop_fifo.sv
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   in_ready and out_valid come straight from flops
`timescale 1ns/1ps
module dcop_fifo
  import dcop_pkg::*;
#(
  parameter int WIDTH = DCOP_WORD_W,
  parameter int DEPTH = DCOP_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
    logic                        in_ready;
    logic                        out_valid;
  } dcop_fifo_s;

  dcop_fifo_s st;
  dcop_fifo_s next_st;
  logic       push;
  logic       pop;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction : bump

  always_comb begin
    next_st = st;
    push    = in_valid & st.in_ready;
    pop     = st.out_valid & out_ready;
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data;
      next_st.wr_ptr         = bump(st.wr_ptr);
    end
    if (pop) begin
      next_st.rd_ptr = bump(st.rd_ptr);
    end
    case ({push, pop})
      2'b10:   next_st.count = st.count + CNT_W'(1);
      2'b01:   next_st.count = st.count - CNT_W'(1);
      default: next_st.count = st.count;
    endcase
    next_st.in_ready  = (next_st.count != CNT_W'(DEPTH));
    next_st.out_valid = (next_st.count != '0);
    if (rst) begin
      next_st          = '0;
      next_st.in_ready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign in_ready  = st.in_ready;
  assign out_valid = st.out_valid;
  assign out_data  = st.mem[st.rd_ptr];

endmodule : dcop_fifo

// >>> core/dcop_pkg.sv
// Purpose: shared constants and types for the daisy-chain output port
// Assumes: mclk at 100 MHz, link clock is the x4 multiplied chain clock
// Notes:   offsets, counts and carrier reset values live here
package dcop_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // widths and depths
  localparam int DCOP_BYTE_W     = 8;
  localparam int DCOP_FIFO_DEPTH = 4;
  localparam int DCOP_HOLD_W     = 16;
  localparam int DCOP_TICK_W     = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int DCOP_MCLK_PERIOD_NS  = 10;
  localparam int DCOP_HOLD_TICK_NS    = 1000;
  localparam int DCOP_HOLD_TICK_CYC   =
    (DCOP_HOLD_TICK_NS + DCOP_MCLK_PERIOD_NS - 1) / DCOP_MCLK_PERIOD_NS;
  localparam int DCOP_CLK_MULT        = 4;
  localparam int DCOP_LOCK_EDGES      = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic                   frame;
    logic [DCOP_BYTE_W-1:0] data;
  } dcop_word_s;

  typedef struct packed {
    logic                   response;
    logic                   frame;
    logic [DCOP_BYTE_W-1:0] data;
  } dcop_chain_s;

  localparam int DCOP_WORD_W = $bits(dcop_word_s);

  localparam dcop_word_s  DCOP_WORD_RESET  = '{frame: 1'b0, data: 8'h00};
  localparam dcop_chain_s DCOP_CHAIN_RESET = '{response: 1'b0, frame: 1'b0, data: 8'h00};

  ////////////////////////////////////////////////////////////////////////////////
  // state encodings, gray along the usual path
  typedef enum logic [1:0] {
    DCOP_HOLD_IDLE = 2'b00,
    DCOP_HOLD_WAIT = 2'b01,
    DCOP_HOLD_OPEN = 2'b11
  } dcop_hold_e;

  typedef enum logic [1:0] {
    DCOP_TEST_IDLE = 2'b00,
    DCOP_TEST_RUN  = 2'b01,
    DCOP_TEST_DONE = 2'b11
  } dcop_test_e;

endpackage : dcop_pkg

// >>> core/dcop_port.sv
// Purpose: daisy-chain output port of an accumulator controller
// Assumes: link_clk is the chain clock multiplied by four on chip;
//          own stream, holdoff and memory test inputs are on mclk
// Notes:   every output is a flop; link outputs on link_clk
`timescale 1ns/1ps
module dcop_port
  import dcop_pkg::*;
(
  // system clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // multiplied chain clock
  input  wire logic                   link_clk,
  // chain inputs from upstream and downstream
  input  wire logic                   chain_clock_in,
  input  wire logic                   port_select_n,
  input  wire logic                   serial_command_in,
  input  wire logic                   chain_response_in,
  input  wire logic [DCOP_BYTE_W-1:0] chain_byte_in,
  input  wire logic                   chain_frame_in,
  // chain outputs
  output logic                        chain_clock_out,
  output logic                        serial_command_out,
  output logic                        serial_response,
  output logic      [DCOP_BYTE_W-1:0] output_byte_bus,
  output logic                        output_byte_bus_oe,
  output logic                        frame_out,
  output logic                        chain_locked,
  // own data stream
  input  wire logic                   src_valid,
  input  wire dcop_word_s             src_word,
  output logic                        src_ready,
  input  wire logic                   own_response,
  // transmit holdoff
  input  wire logic                   holdoff_timed,
  input  wire logic [DCOP_HOLD_W-1:0] holdoff_count,
  input  wire logic                   holdoff_release,
  output logic                        holdoff_active,
  // memory self-test
  input  wire logic                   powered_up_flag,
  input  wire logic                   mem_test_start,
  input  wire logic                   mem_pass_done,
  input  wire logic                   mem_pass_fail,
  output logic                        mem_test_running,
  output logic                        mem_test_done,
  output logic                        mem_test_failed
);

  ////////////////////////////////////////////////////////////////////////////////
  // state of the mclk side
  typedef struct packed {
    dcop_hold_e             hold_state;
    logic                   hold_timed;
    logic [DCOP_TICK_W-1:0] tick;
    logic [DCOP_HOLD_W-1:0] hold_left;
    logic                   req_tog;
    logic                   busy;
    dcop_word_s             xfer;
    logic                   holdoff_active;
    dcop_test_e             test_state;
    logic                   test_failed;
    logic                   mem_test_running;
    logic                   mem_test_done;
  } dcop_core_s;

  // state of the link side
  typedef struct packed {
    logic        req_seen;
    logic        ack_tog;
    dcop_word_s  own;
    logic        own_valid;
    logic        clk_seen;
    logic [1:0]  phase;
    logic [1:0]  lock_cnt;
    logic        locked;
    dcop_chain_s chain;
    logic        byte_oe;
    logic        chain_clock_out;
    logic        serial_command_out;
  } dcop_link_s;

  localparam dcop_core_s CORE_RESET = '{
    hold_state:       DCOP_HOLD_IDLE,
    hold_timed:       1'b0,
    tick:             '0,
    hold_left:        '0,
    req_tog:          1'b0,
    busy:             1'b0,
    xfer:             DCOP_WORD_RESET,
    holdoff_active:   1'b0,
    test_state:       DCOP_TEST_IDLE,
    test_failed:      1'b0,
    mem_test_running: 1'b0,
    mem_test_done:    1'b0
  };

  localparam dcop_link_s LINK_RESET = '{
    req_seen:           1'b0,
    ack_tog:            1'b0,
    own:                DCOP_WORD_RESET,
    own_valid:          1'b0,
    clk_seen:           1'b0,
    phase:              2'b00,
    lock_cnt:           2'b00,
    locked:             1'b0,
    chain:              DCOP_CHAIN_RESET,
    byte_oe:            1'b0,
    chain_clock_out:    1'b0,
    serial_command_out: 1'b0
  };

  localparam logic [1:0] PHASE_LAST  = 2'(DCOP_CLK_MULT - 1);
  localparam logic [1:0] PHASE_HALF  = 2'(DCOP_CLK_MULT / 2);
  localparam logic [1:0] LOCK_FULL   = 2'(DCOP_LOCK_EDGES);
  localparam int         LSYNC_W     = 8 + DCOP_BYTE_W;

  dcop_core_s core;
  dcop_core_s next_core;
  dcop_link_s lnk;
  dcop_link_s next_lnk;

  ////////////////////////////////////////////////////////////////////////////////
  // own data buffer on mclk
  logic                   fifo_valid;
  logic [DCOP_WORD_W-1:0] fifo_data;
  logic                   fifo_take;

  // back-pressure reaches src_ready when the link or holdoff stalls
  dcop_fifo #(
    .WIDTH (DCOP_WORD_W),
    .DEPTH (DCOP_FIFO_DEPTH)
  ) u_fifo (
    .clk       (mclk),
    .rst       (rst),
    .in_valid  (src_valid),
    .in_data   (src_word),
    .in_ready  (src_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_take)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // crossings
  logic [LSYNC_W-1:0] lsync_q;
  logic               ack_s;
  logic               s_rst;
  logic               s_req;
  logic               s_clk;
  logic               s_sel_n;
  logic               s_cmd;
  logic               s_resp;
  logic               s_frame;
  logic               s_own_resp;
  logic [DCOP_BYTE_W-1:0] s_byte;

  // all chain pins pass two link flops before use
  dcop_sync #(
    .WIDTH (LSYNC_W)
  ) u_link_sync (
    .clk (link_clk),
    .d   ({rst, core.req_tog, chain_clock_in, port_select_n, serial_command_in,
           chain_response_in, chain_frame_in, own_response, chain_byte_in}),
    .q   (lsync_q)
  );

  dcop_sync #(
    .WIDTH (1)
  ) u_ack_sync (
    .clk (mclk),
    .d   (lnk.ack_tog),
    .q   (ack_s)
  );

  assign {s_rst, s_req, s_clk, s_sel_n, s_cmd, s_resp, s_frame, s_own_resp, s_byte} = lsync_q;

  ////////////////////////////////////////////////////////////////////////////////
  // mclk side: holdoff, word hand-off, memory test
  assign fifo_take = fifo_valid & ~core.busy & (core.hold_state == DCOP_HOLD_OPEN);

  always_comb begin
    next_core = core;

    // hand-off completes when the link echoes the toggle
    if (core.busy && (ack_s == core.req_tog)) begin
      next_core.busy = 1'b0;
    end
    if (fifo_take) begin
      next_core.xfer    = dcop_word_s'(fifo_data);
      next_core.req_tog = ~core.req_tog;
      next_core.busy    = 1'b1;
    end

    // one holdoff per burst of ready data
    case (core.hold_state)
      DCOP_HOLD_IDLE: begin
        if (fifo_valid) begin
          next_core.hold_timed = holdoff_timed;
          next_core.hold_left  = holdoff_count;
          next_core.tick       = '0;
          if (holdoff_timed && (holdoff_count == '0)) begin
            next_core.hold_state = DCOP_HOLD_OPEN;
          end else begin
            next_core.hold_state = DCOP_HOLD_WAIT;
          end
        end
      end
      DCOP_HOLD_WAIT: begin
        if (!core.hold_timed) begin
          if (holdoff_release) begin
            next_core.hold_state = DCOP_HOLD_OPEN;
          end
        end else if (core.tick == DCOP_TICK_W'(DCOP_HOLD_TICK_CYC - 1)) begin
          next_core.tick = '0;
          if (core.hold_left <= DCOP_HOLD_W'(1)) begin
            next_core.hold_state = DCOP_HOLD_OPEN;
          end else begin
            next_core.hold_left = core.hold_left - DCOP_HOLD_W'(1);
          end
        end else begin
          next_core.tick = core.tick + DCOP_TICK_W'(1);
        end
      end
      DCOP_HOLD_OPEN: begin
        if (!fifo_valid && !core.busy) begin
          next_core.hold_state = DCOP_HOLD_IDLE;
        end
      end
      default: begin
        next_core.hold_state = DCOP_HOLD_IDLE;
      end
    endcase
    next_core.holdoff_active = (next_core.hold_state == DCOP_HOLD_WAIT);

    // memory self-test sequencing
    case (core.test_state)
      DCOP_TEST_IDLE: begin
        if (mem_test_start) begin
          next_core.test_state  = DCOP_TEST_RUN;
          next_core.test_failed = 1'b0;
        end
      end
      DCOP_TEST_RUN: begin
        if (mem_pass_fail) begin
          // stay running so the memory pins can be probed
          next_core.test_failed = 1'b1;
        end else if (mem_pass_done && powered_up_flag && !core.test_failed) begin
          next_core.test_state = DCOP_TEST_DONE;
        end
      end
      DCOP_TEST_DONE: begin
        if (mem_test_start) begin
          next_core.test_state  = DCOP_TEST_RUN;
          next_core.test_failed = 1'b0;
        end
      end
      default: begin
        next_core.test_state = DCOP_TEST_IDLE;
      end
    endcase
    next_core.mem_test_running = (next_core.test_state == DCOP_TEST_RUN);
    next_core.mem_test_done    = (next_core.test_state == DCOP_TEST_DONE);

    if (rst) begin
      next_core = CORE_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    core <= next_core;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link side: clock regeneration, word pick-up, output mux
  dcop_chain_s own_chain;
  dcop_chain_s fwd_chain;
  logic        clk_edge;

  always_comb begin
    next_lnk = lnk;

    // xfer is held stable by busy until the ack returns
    next_lnk.req_seen  = s_req;
    next_lnk.own_valid = 1'b0;
    if (s_req != lnk.req_seen) begin
      next_lnk.own       = core.xfer;
      next_lnk.own_valid = 1'b1;
      next_lnk.ack_tog   = ~lnk.ack_tog;
    end

    // four link_clk cycles per chain clock period when in lock
    clk_edge          = s_clk & ~lnk.clk_seen;
    next_lnk.clk_seen = s_clk;
    if (clk_edge) begin
      next_lnk.phase = 2'b00;
      if (lnk.phase == PHASE_LAST) begin
        next_lnk.lock_cnt = (lnk.lock_cnt == LOCK_FULL) ? LOCK_FULL
                                                        : lnk.lock_cnt + 2'b01;
      end else begin
        next_lnk.lock_cnt = 2'b00;
      end
    end else begin
      next_lnk.phase = lnk.phase + 2'b01;
    end
    next_lnk.locked          = (next_lnk.lock_cnt == LOCK_FULL);
    // same pipeline depth as the data, so clock and data stay aligned
    next_lnk.chain_clock_out = (next_lnk.phase < PHASE_HALF);

    own_chain = '{response: s_own_resp,
                  frame:    lnk.own_valid & lnk.own.frame,
                  data:     lnk.own.data};
    fwd_chain = '{response: s_resp, frame: s_frame, data: s_byte};

    // registered mux: no combinational path from select to pins
    next_lnk.chain   = s_sel_n ? fwd_chain : own_chain;
    next_lnk.byte_oe = ~s_sel_n;

    next_lnk.serial_command_out = s_cmd;

    if (s_rst) begin
      next_lnk = LINK_RESET;
    end
  end

  always_ff @(posedge link_clk) begin
    lnk <= next_lnk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign chain_clock_out    = lnk.chain_clock_out;
  assign serial_command_out = lnk.serial_command_out;
  assign serial_response    = lnk.chain.response;
  assign output_byte_bus    = lnk.chain.data;
  assign output_byte_bus_oe = lnk.byte_oe;
  assign frame_out          = lnk.chain.frame;
  assign chain_locked       = lnk.locked;
  assign holdoff_active     = core.holdoff_active;
  assign mem_test_running   = core.mem_test_running;
  assign mem_test_done      = core.mem_test_done;
  assign mem_test_failed    = core.test_failed;

endmodule : dcop_port

// >>> core/dcop_sync.sv
// Purpose: two-flop synchroniser for a bundle of levels
// Assumes: each bit is an independent level or a toggle
// Notes:   no reset, the chain flushes within two edges
`timescale 1ns/1ps
module dcop_sync
  import dcop_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock
  input  wire logic             clk,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } dcop_sync_s;

  dcop_sync_s st;
  dcop_sync_s next_st;

  always_comb begin
    next_st        = st;
    next_st.stage1 = d;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign q = st.stage2;

endmodule : dcop_sync

// >>> verif/dcop_chain_model.sv
// Purpose: transmitter and downstream controllers seen from the port
// Assumes: link_clk is the multiplied chain clock
// Notes:   downstream response and byte change every cycle, frame every other, so stale values show
`timescale 1ns/1ps
module dcop_chain_model
  import dcop_pkg::*;
(
  // link clock and select request
  input  wire logic                   link_clk,
  input  wire logic                   select_req,
  // pins into the port
  output logic                        chain_clock_in,
  output logic                        port_select_n,
  output logic                        serial_command_in,
  output logic                        chain_response_in,
  output logic      [DCOP_BYTE_W-1:0] chain_byte_in,
  output logic                        chain_frame_in
);
  logic [1:0] phase;
  logic [7:0] lfsr;

  initial begin
    phase             = 2'h0;
    lfsr              = 8'h5a;
    chain_clock_in    = 1'b0;
    port_select_n     = 1'b1;
    chain_response_in = 1'b0;
    chain_byte_in     = 8'h00;
    chain_frame_in    = 1'b0;
  end

  assign serial_command_in = lfsr[0];

  always @(posedge link_clk) begin
    phase          <= phase + 2'h1;
    chain_clock_in <= (phase == 2'h3) || (phase == 2'h0);
    // command moves only with the rising chain clock
    if (phase == 2'h3) lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    port_select_n     <= !select_req;
    chain_response_in <= !chain_response_in;
    chain_byte_in     <= chain_byte_in + 8'h01;
    chain_frame_in    <= chain_byte_in[1];
  end
endmodule : dcop_chain_model

// >>> verif/dcop_port_monitor.sv
// Purpose: concurrent checks on the chain port pins
// Assumes: link side settles 7 link edges after reset release
// Notes:   bound to every dcop_port instance
`timescale 1ns/1ps
module dcop_port_monitor
  import dcop_pkg::*;
(
  // clocks and reset
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   link_clk,
  // chain pins
  input wire logic                   port_select_n,
  input wire logic                   serial_command_in,
  input wire logic                   chain_response_in,
  input wire logic [DCOP_BYTE_W-1:0] chain_byte_in,
  input wire logic                   chain_frame_in,
  input wire logic                   chain_clock_out,
  input wire logic                   serial_command_out,
  input wire logic                   serial_response,
  input wire logic [DCOP_BYTE_W-1:0] output_byte_bus,
  input wire logic                   output_byte_bus_oe,
  input wire logic                   frame_out,
  input wire logic                   chain_locked,
  // holdoff and memory test
  input wire logic                   holdoff_timed,
  input wire logic                   holdoff_release,
  input wire logic                   holdoff_active,
  input wire logic                   powered_up_flag,
  input wire logic                   mem_pass_done,
  input wire logic                   mem_pass_fail,
  input wire logic                   mem_test_running,
  input wire logic                   mem_test_done,
  input wire logic                   mem_test_failed
);
  logic [2:0] link_up;
  logic       cpu_mode;
  wire        ok = (link_up == 3'h7);

  // link reset lags by its synchronisers
  always_ff @(posedge link_clk) begin
    if (rst) link_up <= 3'h0;
    else if (!ok) link_up <= link_up + 3'h1;
  end
  // holdoff mode is frozen once the wait starts
  always_ff @(posedge mclk) begin
    if (rst) cpu_mode <= 1'b0;
    else if (!holdoff_active) cpu_mode <= !holdoff_timed;
  end

  ////////////////////////////////////////////////////////////
  chk_cmd_copy: assert property (@(posedge link_clk) disable iff (rst)
    ok |-> serial_command_out == $past(serial_command_in, 3))
    else $error("command copy mismatch");
  chk_own_drive: assert property (@(posedge link_clk) disable iff (rst)
    ok |-> output_byte_bus_oe == !$past(port_select_n, 3))
    else $error("byte bus enable mismatch");
  chk_fwd_path: assert property (@(posedge link_clk) disable iff (rst)
    ok && $past(port_select_n, 3) |-> serial_response == $past(chain_response_in, 3)
      && frame_out == $past(chain_frame_in, 3) && output_byte_bus == $past(chain_byte_in, 3))
    else $error("forwarded signals mismatch");
  chk_own_pulse: assert property (@(posedge link_clk) disable iff (rst)
    ok && frame_out && !$past(port_select_n, 3) && !$past(port_select_n, 2) |=> !frame_out)
    else $error("own frame longer than one cycle");
  chk_clk_shape: assert property (@(posedge link_clk) disable iff (rst)
    ok && chain_locked && $rose(chain_clock_out) |=>
      chain_clock_out ##1 !chain_clock_out [*2] ##1 chain_clock_out)
    else $error("chain clock shape wrong");
  chk_clk_phase: assert property (@(posedge link_clk) disable iff (rst)
    ok && chain_locked && $changed(serial_command_out) |-> $rose(chain_clock_out))
    else $error("chain clock out of phase");
  chk_test_done: assert property (@(posedge mclk) disable iff (rst)
    mem_test_running && !mem_test_failed && !mem_pass_fail && mem_pass_done
      && powered_up_flag |=> mem_test_done && !mem_test_running)
    else $error("memory test did not finish");
  chk_done_cause: assert property (@(posedge mclk) disable iff (rst)
    $rose(mem_test_done) |-> $past(powered_up_flag) && $past(mem_pass_done))
    else $error("memory test finished early");
  chk_fail_runs: assert property (@(posedge mclk) disable iff (rst)
    mem_test_failed |=> mem_test_failed && mem_test_running && !mem_test_done)
    else $error("failed memory test stopped");
  chk_cpu_release: assert property (@(posedge mclk) disable iff (rst)
    holdoff_active && cpu_mode && holdoff_release |=> !holdoff_active)
    else $error("holdoff release ignored");

  cov_own: cover property (@(posedge link_clk) disable iff (rst) $rose(output_byte_bus_oe));
  cov_done: cover property (@(posedge mclk) disable iff (rst) $rose(mem_test_done));
  cov_fail: cover property (@(posedge mclk) disable iff (rst) $rose(mem_test_failed));
  cov_open: cover property (@(posedge mclk) disable iff (rst) $fell(holdoff_active));
endmodule : dcop_port_monitor

bind dcop_port dcop_port_monitor mon_u (
  .mclk, .rst, .link_clk, .port_select_n, .serial_command_in, .chain_response_in,
  .chain_byte_in, .chain_frame_in, .chain_clock_out, .serial_command_out, .serial_response,
  .output_byte_bus, .output_byte_bus_oe, .frame_out, .chain_locked, .holdoff_timed,
  .holdoff_release, .holdoff_active, .powered_up_flag, .mem_pass_done, .mem_pass_fail,
  .mem_test_running, .mem_test_done, .mem_test_failed
);

// >>> verif/dcop_port_tb.sv
// Purpose: self-checking bench for the daisy-chain output port
// Assumes: link clock 80 ns, offset from mclk so edges never meet
// Notes:   own words all carry frame so each one is seen on the chain
`timescale 1ns/1ps
module dcop_port_tb
  import dcop_pkg::*;
;
  logic                   mclk = 1'b0;
  logic                   link_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   select_req = 1'b0;
  logic                   src_valid = 1'b0;
  dcop_word_s             src_word = DCOP_WORD_RESET;
  logic                   own_response = 1'b0;
  logic                   holdoff_timed = 1'b0;
  logic [DCOP_HOLD_W-1:0] holdoff_count = 16'h0000;
  logic                   holdoff_release = 1'b0;
  logic                   powered_up_flag = 1'b0;
  logic                   mem_test_start = 1'b0;
  logic                   mem_pass_done = 1'b0;
  logic                   mem_pass_fail = 1'b0;
  logic                   chain_clock_in, port_select_n, serial_command_in, chain_response_in;
  logic                   chain_frame_in, chain_clock_out, serial_command_out, serial_response;
  logic                   output_byte_bus_oe, frame_out, chain_locked, src_ready;
  logic                   holdoff_active, mem_test_running, mem_test_done, mem_test_failed;
  logic [DCOP_BYTE_W-1:0] chain_byte_in, output_byte_bus;
  logic [8:0]             exp_q[$];
  int                     failures = 0;
  int                     compares = 0;
  int                     seed = 48;
  int                     n, k;

  always #5 mclk = ~mclk;
  initial #3 forever #40 link_clk = ~link_clk;

  dcop_chain_model model_u (.link_clk, .select_req, .chain_clock_in, .port_select_n,
    .serial_command_in, .chain_response_in, .chain_byte_in, .chain_frame_in);

  dcop_port dut_u (.mclk, .rst, .link_clk, .chain_clock_in, .port_select_n, .serial_command_in,
    .chain_response_in, .chain_byte_in, .chain_frame_in, .chain_clock_out, .serial_command_out,
    .serial_response, .output_byte_bus, .output_byte_bus_oe, .frame_out, .chain_locked,
    .src_valid, .src_word, .src_ready, .own_response, .holdoff_timed, .holdoff_count,
    .holdoff_release, .holdoff_active, .powered_up_flag, .mem_test_start, .mem_pass_done,
    .mem_pass_fail, .mem_test_running, .mem_test_done, .mem_test_failed);

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // valid stays up between back-to-back words
  task automatic send(input logic [7:0] d);
    @(negedge mclk);
    src_valid = 1'b1;
    src_word  = '{frame: 1'b1, data: d};
    do @(posedge mclk); while (src_ready !== 1'b1);
    exp_q.push_back({1'b1, d});
  endtask : send

  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
    repeat (2) @(negedge mclk);
  endtask : pulse

  task automatic wait_empty;
    for (int i = 0; i < 2000 && exp_q.size() != 0; i++) @(negedge mclk);
    check({15'h0000, exp_q.size() == 0}, 16'h0001);
  endtask : wait_empty

  // each own frame pulse takes the oldest expected word
  always @(negedge link_clk) begin
    if (!rst && output_byte_bus_oe === 1'b1 && frame_out === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0001, 16'h0000);
      else check({6'h00, serial_response, frame_out, output_byte_bus},
                 {6'h00, own_response, exp_q.pop_front()});
    end
  end

  // well under a thousand mclk cycles are needed; the limit allows 20000
  initial begin
    #200_000;
    failures++;
    stop_test();
  end

  initial begin
    repeat (32) @(negedge mclk);
    rst = 1'b0;
    repeat (40) @(negedge mclk);
    check({15'h0000, output_byte_bus_oe}, 16'h0000);
    $display("forward test done");
    select_req   = 1'b1;
    own_response = 1'($random(seed));
    for (int i = 0; i < 4; i++) send(8'($random(seed)));
    @(negedge mclk);
    src_valid = 1'b0;
    repeat (3) @(negedge mclk);
    check({14'h0000, src_ready, holdoff_active}, 16'h0001);
    pulse(holdoff_release);
    wait_empty();
    check({15'h0000, src_ready}, 16'h0001);
    $display("processor holdoff test done");
    holdoff_timed = 1'b1;
    k             = ($random(seed) & 1) + 1;
    holdoff_count = 16'(k);
    send(8'($random(seed)));
    @(negedge mclk);
    src_valid = 1'b0;
    @(negedge mclk);
    n = 0;
    while (holdoff_active === 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    check({15'h0000, n >= k * 100 - 2 && n <= k * 100}, 16'h0001);
    wait_empty();
    $display("timed holdoff test done");
    pulse(mem_test_start);
    pulse(mem_pass_done);
    check({13'h0000, mem_test_running, mem_test_done, mem_test_failed}, 16'h0004);
    powered_up_flag = 1'b1;
    pulse(mem_pass_done);
    check({13'h0000, mem_test_running, mem_test_done, mem_test_failed}, 16'h0002);
    pulse(mem_test_start);
    pulse(mem_pass_fail);
    pulse(mem_pass_done);
    check({13'h0000, mem_test_running, mem_test_done, mem_test_failed}, 16'h0005);
    $display("memory test done");
    select_req = 1'b0;
    repeat (40) @(negedge mclk);
    check({15'h0000, output_byte_bus_oe}, 16'h0000);
    check({15'h0000, chain_locked}, 16'h0001);
    $display("deselect test done");
    stop_test();
  end
endmodule : dcop_port_tb
